// >>> shared/ccr_pkg.sv
package ccr_pkg;
  // ------------------------------------------------------------
  // Register offsets on the peripheral port
  // ------------------------------------------------------------
  localparam logic [7:0] CCR_ADDR_CONFIG_A = 8'h18;
  localparam logic [7:0] CCR_ADDR_COMMAND = 8'h19;
  localparam logic [7:0] CCR_ADDR_OUT_LOW = 8'h1a;
  localparam logic [7:0] CCR_ADDR_OUT_HIGH = 8'h1b;
  localparam logic [7:0] CCR_ADDR_IN_LOW = 8'h1c;
  localparam logic [7:0] CCR_ADDR_IN_HIGH = 8'h1d;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CCR_BIT_POWER_ON = 7;
  localparam int CCR_BIT_SHORT = 6;
  localparam int CCR_BIT_SRC_HI = 5;
  localparam int CCR_BIT_SRC_LO = 4;
  localparam int CCR_BIT_DIRECTION = 3;
  localparam int CCR_BIT_SNAPSHOT = 7;
  localparam int CCR_BIT_CLR_OUT = 6;
  localparam int CCR_BIT_CLR_IN = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0] CCR_SRC_RESET = 2'h0;
  localparam logic [15:0] CCR_COUNT_RESET = 16'h0000;
  localparam logic [7:0] CCR_BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    CCR_SRC_CPU,
    CCR_SRC_ADC,
    CCR_SRC_TIMER_A,
    CCR_SRC_TIMER_B
  } ccr_src_e;

  // Register-port request from the CPU.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_req_s;

  // Asynchronous events from outside the CPU clock domain.
  typedef struct packed {
    logic inflow_tick;
    logic outflow_tick;
    logic direction;
    logic adc_busy;
    logic timer_a_ovf;
    logic timer_b_ovf;
  } ccr_evt_s;
endpackage

// >>> rtl/ccr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ccr_sync (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire ccr_pkg::ccr_evt_s async_in,
  output ccr_pkg::ccr_evt_s sync_out
);
  import ccr_pkg::*;

  ccr_evt_s stage1_r;
  ccr_evt_s stage2_r;

  // ------------------------------------------------------------
  // Two-flop synchroniser for every asynchronous event line
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else if (clk_en_in) begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;
endmodule
`default_nettype wire

// >>> rtl/ccr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module ccr_regs (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire ccr_pkg::ccr_req_s req_in,
  input wire ccr_pkg::ccr_evt_s evt_in,
  output logic [7:0] rdata_out,
  output logic gauge_power_on_out,
  output logic sense_input_short_out,
  output logic inflow_overflow_out,
  output logic outflow_overflow_out,
  output logic direction_change_event_out
);
  import ccr_pkg::*;

  ccr_evt_s evt_s;
  ccr_evt_s evt_d_r;

  logic power_on_r;
  logic short_r;
  logic [1:0] src_r;
  logic [15:0] in_cnt_r;
  logic [15:0] in_cnt_nxt;
  logic [15:0] out_cnt_r;
  logic [15:0] out_cnt_nxt;
  logic [15:0] in_hold_r;
  logic [15:0] out_hold_r;
  logic [7:0] rdata_r;
  logic in_ovf_r;
  logic out_ovf_r;
  logic dir_evt_r;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  ccr_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .async_in(evt_in),
    .sync_out(evt_s)
  );

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      evt_d_r <= '0;
    end else if (clk_en_in) begin
      evt_d_r <= evt_s;
    end
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire wr_cfg = req_in.wr && (req_in.addr == CCR_ADDR_CONFIG_A);
  wire wr_cmd = req_in.wr && (req_in.addr == CCR_ADDR_COMMAND);
  wire cmd_ok = wr_cmd && (src_r == CCR_SRC_CPU);
  wire cmd_snap = cmd_ok && req_in.wdata[CCR_BIT_SNAPSHOT];
  wire cmd_clr_out = cmd_ok && req_in.wdata[CCR_BIT_CLR_OUT];
  wire cmd_clr_in = cmd_ok && req_in.wdata[CCR_BIT_CLR_IN];

  // Edges are taken only from the second synchroniser stage onward.
  wire in_tick = evt_s.inflow_tick && !evt_d_r.inflow_tick;
  wire out_tick = evt_s.outflow_tick && !evt_d_r.outflow_tick;
  wire adc_edge = evt_s.adc_busy ^ evt_d_r.adc_busy;
  wire ta_edge = evt_s.timer_a_ovf && !evt_d_r.timer_a_ovf;
  wire tb_edge = evt_s.timer_b_ovf && !evt_d_r.timer_b_ovf;
  wire dir_edge = evt_s.direction ^ evt_d_r.direction;

  wire hw_latch = (src_r == CCR_SRC_ADC && adc_edge) ||
                  (src_r == CCR_SRC_TIMER_A && ta_edge) ||
                  (src_r == CCR_SRC_TIMER_B && tb_edge);
  wire do_latch = cmd_snap || hw_latch;

  wire in_inc = power_on_r && in_tick;
  wire out_inc = power_on_r && out_tick;
  wire in_wrap = in_inc && (in_cnt_r == 16'hffff);
  wire out_wrap = out_inc && (out_cnt_r == 16'hffff);

  // ------------------------------------------------------------
  // Counter next values
  // ------------------------------------------------------------
  always_comb begin
    in_cnt_nxt = in_cnt_r;
    out_cnt_nxt = out_cnt_r;
    if (in_inc) begin
      in_cnt_nxt = in_cnt_r + 16'h0001;
    end
    if (out_inc) begin
      out_cnt_nxt = out_cnt_r + 16'h0001;
    end
    if (cmd_clr_in) begin
      in_cnt_nxt = CCR_COUNT_RESET;
    end
    if (cmd_clr_out) begin
      out_cnt_nxt = CCR_COUNT_RESET;
    end
  end

  wire [7:0] cfg_rd = {power_on_r, short_r, src_r, evt_s.direction, 3'h0};
  wire [7:0] rd_mux =
    (req_in.addr == CCR_ADDR_CONFIG_A) ? cfg_rd :
    (req_in.addr == CCR_ADDR_OUT_LOW) ? out_hold_r[7:0] :
    (req_in.addr == CCR_ADDR_OUT_HIGH) ? out_hold_r[15:8] :
    (req_in.addr == CCR_ADDR_IN_LOW) ? in_hold_r[7:0] :
    (req_in.addr == CCR_ADDR_IN_HIGH) ? in_hold_r[15:8] : CCR_BYTE_RESET;

  // ------------------------------------------------------------
  // Configuration
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_on_r <= 1'b0;
      short_r <= 1'b0;
      src_r <= CCR_SRC_RESET;
    end else if (clk_en_in && wr_cfg) begin
      power_on_r <= req_in.wdata[CCR_BIT_POWER_ON];
      short_r <= req_in.wdata[CCR_BIT_SHORT];
      src_r <= req_in.wdata[CCR_BIT_SRC_HI:CCR_BIT_SRC_LO];
    end
  end

  // ------------------------------------------------------------
  // Running counters
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_cnt_r <= CCR_COUNT_RESET;
      out_cnt_r <= CCR_COUNT_RESET;
    end else if (clk_en_in) begin
      in_cnt_r <= in_cnt_nxt;
      out_cnt_r <= out_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // Holding registers
  // ------------------------------------------------------------
  // Capture takes the registered count, which never changes mid-cycle, so
  // an increment in the same cycle shows up only in the next snapshot.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_hold_r <= CCR_COUNT_RESET;
      out_hold_r <= CCR_COUNT_RESET;
    end else if (clk_en_in && do_latch) begin
      in_hold_r <= in_cnt_r;
      out_hold_r <= out_cnt_r;
    end
  end

  // ------------------------------------------------------------
  // Read data and event pulses
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= CCR_BYTE_RESET;
      in_ovf_r <= 1'b0;
      out_ovf_r <= 1'b0;
      dir_evt_r <= 1'b0;
    end else if (clk_en_in) begin
      rdata_r <= req_in.rd ? rd_mux : CCR_BYTE_RESET;
      in_ovf_r <= in_wrap;
      out_ovf_r <= out_wrap;
      dir_evt_r <= dir_edge;
    end
  end

  assign rdata_out = rdata_r;
  assign gauge_power_on_out = power_on_r;
  assign sense_input_short_out = short_r;
  assign inflow_overflow_out = in_ovf_r;
  assign outflow_overflow_out = out_ovf_r;
  assign direction_change_event_out = dir_evt_r;
endmodule
`default_nettype wire

// >>> tb/ccr_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module ccr_chk (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire ccr_pkg::ccr_req_s req_in,
  input wire ccr_pkg::ccr_evt_s evt_in,
  input wire logic [7:0] rdata_out,
  input wire logic gauge_power_on_out,
  input wire logic sense_input_short_out,
  input wire logic inflow_overflow_out,
  input wire logic outflow_overflow_out,
  input wire logic direction_change_event_out
);
  import ccr_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic cfg_wr = clk_en_in && req_in.wr && req_in.addr == CCR_ADDR_CONFIG_A;
  wire logic cfg_rd = clk_en_in && req_in.rd && req_in.addr == CCR_ADDR_CONFIG_A;
  wire logic cmd_rd = clk_en_in && req_in.rd && req_in.addr == CCR_ADDR_COMMAND;
  AST_PWR_WR: assert property (cfg_wr |=> gauge_power_on_out == $past(req_in.wdata[7]))
    else $error("power bit not loaded");
  AST_SHORT_WR: assert property (cfg_wr |=> sense_input_short_out == $past(req_in.wdata[6]))
    else $error("short bit not loaded");
  AST_CFG_RD: assert property (cfg_rd |=> rdata_out[2:0] == 3'h0 &&
    rdata_out[7:6] == {$past(gauge_power_on_out), $past(sense_input_short_out)}) else $error("config read wrong");
  AST_CMD_RD: assert property (cmd_rd |=> rdata_out == 8'h00)
    else $error("command register readable");
  AST_IDLE_RD: assert property (clk_en_in && !req_in.rd |=> rdata_out == 8'h00)
    else $error("read data without read");
  AST_DIR_EVT: assert property ($changed(evt_in.direction) |-> ##[2:6] direction_change_event_out)
    else $error("direction event missing");
  AST_DIR_PULSE: assert property (direction_change_event_out |=> !direction_change_event_out)
    else $error("direction event too long");
  AST_IN_OVF_PULSE: assert property (inflow_overflow_out |=> !inflow_overflow_out)
    else $error("inflow overflow pulse too long");
  AST_OUT_OVF_PULSE: assert property (outflow_overflow_out |=> !outflow_overflow_out)
    else $error("outflow overflow pulse too long");
  AST_RST: assert property ($rose(rst_b_in) |-> !gauge_power_on_out && rdata_out == 8'h00)
    else $error("outputs not cleared by reset");
  AST_FREEZE: assert property (!clk_en_in |=> $stable(gauge_power_on_out))
    else $error("state moved while frozen");
endmodule
bind ccr_regs ccr_chk chk_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
  .req_in(req_in), .evt_in(evt_in), .rdata_out(rdata_out), .gauge_power_on_out(gauge_power_on_out),
  .sense_input_short_out(sense_input_short_out), .inflow_overflow_out(inflow_overflow_out),
  .outflow_overflow_out(outflow_overflow_out), .direction_change_event_out(direction_change_event_out));
`default_nettype wire

// >>> tb/ccr_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Peripheral port master
// ----------------------------------------
module ccr_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output var ccr_pkg::ccr_req_s req_out
);
  import ccr_pkg::*;
  initial req_out = '0;
  // A request stands for exactly one taking edge, so no write is ever applied twice.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    #1 req_out = '{w, !w, a, d};
    @(posedge clk_in);
    #1 req_out = '0;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ccr_pkg::*;
  logic clk, rst_b, clk_en, pwr, shrt;
  logic [7:0] rdata;
  ccr_req_s req;
  ccr_evt_s evt;
  int err_count, cmp_count;
  ccr_regs dut_u (.sys_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en), .req_in(req), .evt_in(evt),
    .rdata_out(rdata), .gauge_power_on_out(pwr), .sense_input_short_out(shrt), .inflow_overflow_out(),
    .outflow_overflow_out(), .direction_change_event_out());
  ccr_cpu_model cpu_u (.clk_in(clk), .rdata_in(rdata), .req_out(req));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    cpu_u.xfer(1'b0, a, 8'h00, q);
    cmp(q, exp);
  endtask
  // Event lines pass a two-flop synchroniser, so each level is held for four edges.
  task automatic pulse(input int f);
    @(posedge clk);
    #1 evt[f] = 1'b1;
    repeat (4) @(posedge clk);
    #1 evt[f] = 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 8'h18; a <= 8'h1e; a++) rdc(8'(a), 8'h00);
  endtask
  task automatic t_count;
    pulse(5);
    wr(CCR_ADDR_CONFIG_A, 8'h80);
    cmp({7'h0, pwr}, 8'h01);
    repeat (3) pulse(4);
    repeat (5) pulse(5);
    wr(CCR_ADDR_COMMAND, 8'h80);
    rdc(CCR_ADDR_OUT_LOW, 8'h03);
    rdc(CCR_ADDR_OUT_HIGH, 8'h00);
    rdc(CCR_ADDR_IN_LOW, 8'h05);
    rdc(CCR_ADDR_IN_HIGH, 8'h00);
    pulse(5);
    wr(CCR_ADDR_COMMAND, 8'h80);
    rdc(CCR_ADDR_IN_LOW, 8'h06);
  endtask
  task automatic t_clear;
    wr(CCR_ADDR_COMMAND, 8'h40);
    wr(CCR_ADDR_COMMAND, 8'h80);
    rdc(CCR_ADDR_OUT_LOW, 8'h00);
    rdc(CCR_ADDR_IN_LOW, 8'h06);
    wr(CCR_ADDR_COMMAND, 8'h20);
    wr(CCR_ADDR_COMMAND, 8'h80);
    rdc(CCR_ADDR_IN_LOW, 8'h00);
  endtask
  // Each mode counts once before its source edge, so a stale holding value or a wrongly
  // obeyed clear shows up; the second tick lands between the two edges of the source.
  task automatic t_modes;
    for (int m = 1; m < 4; m++) begin
      wr(CCR_ADDR_CONFIG_A, 8'h80 | 8'(m << 4));
      wr(CCR_ADDR_COMMAND, 8'he0);
      pulse(5);
      evt[3 - m] = 1'b1;
      repeat (4) @(posedge clk);
      pulse(5);
      #1 evt[3 - m] = 1'b0;
      repeat (4) @(posedge clk);
      wr(CCR_ADDR_CONFIG_A, 8'h80);
      rdc(CCR_ADDR_IN_LOW, (m == 1) ? 8'h02 : 8'(2 * m - 1));
    end
  endtask
  task automatic t_dir;
    evt[3] = 1'b1;
    repeat (8) @(posedge clk);
    rdc(CCR_ADDR_CONFIG_A, 8'h88);
    wr(CCR_ADDR_CONFIG_A, 8'hc0);
    cmp({7'h0, shrt}, 8'h01);
    rdc(CCR_ADDR_CONFIG_A, 8'hc8);
    clk_en = 1'b0;
    wr(CCR_ADDR_CONFIG_A, 8'h00);
    clk_en = 1'b1;
    cmp({7'h0, pwr}, 8'h01);
    evt[3] = 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    evt = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset;
    t_count;
    t_clear;
    t_modes;
    t_dir;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
